// >>> include/drive_run_regs.svh
// Purpose: constants for the run-command arbitration block
// Assumes: 25 MHz core clock
// Notes: codes and timing figures used by the block and its checks
`ifndef DRIVE_RUN_REGS_SVH
`define DRIVE_RUN_REGS_SVH
// run command source codes
`define SRC_PANEL        2'h0
`define SRC_TERMINAL     2'h1
`define SRC_COMM         2'h2
// terminal command styles
`define STYLE_TWO_WIRE   2'h0
`define STYLE_THREE_WIRE 2'h1
// start and stop methods
`define START_DIRECT     2'h0
`define START_TRACK      2'h1
`define START_PREEXC     2'h2
`define STOP_DECEL       1'h0
`define STOP_COAST       1'h1
// digital input function codes
`define FUNC_FWD         6'h01
`define FUNC_REV         6'h02
`define FUNC_STOP_HOLD   6'h03
`define FUNC_FWD_INCH    6'h04
`define FUNC_REV_INCH    6'h05
// main frequency sources and reset selection
`define MAIN_SOURCES     9
`define MAIN_SEL_RESET   9'h001
// timing
`define CLK_KHZ          25000
`define TIMEOUT_UNIT_MS  100
`define PREEXC_TIME_MS   50
`endif

// >>> include/drive_run_pkg.sv
// Purpose: types shared by the run-command arbitration block
// Assumes: nothing beyond the constants header
// Notes: drive sequencing states, Gray coded along idle-start-run-stop
package drive_run_pkg;
	typedef enum logic [1:0] {
		ST_IDLE  = 2'h0,
		ST_START = 2'h1,
		ST_RUN   = 2'h3,
		ST_STOP  = 2'h2
	} drive_state_type;
endpackage : drive_run_pkg

// >>> hw/drive_run_command_control.sv
// Purpose: selects and sequences run, stop, direction and jog commands for a motor drive
// Assumes: keys and terminal inputs are asynchronous; host frame strobes are on core_clk
// Notes: clk_en low freezes all state; all outputs come from flip-flops
// Notes on behaviour
// - source code 0 panel keys, 1 terminal inputs, 2 serial host.
// - panel run key starts and lights indicator; stop key stops and darkens it.
// - terminal style setting and per-input function selects decide start/stop inputs.
// - two-wire: forward switch closed runs forward, opening stops unless reverse alone.
// - two-wire: reverse switch closed runs reverse, opening stops unless forward alone.
// - two-wire: both switches closed or both open means stop.
// - three-wire: stop input held closed while running; opening stops at once.
// - three-wire: start and reverse buttons act only on their closing edge.
// - three-wire: latest button action decides run and direction.
// - serial source takes start and stop commands from the host.
// - nonzero timeout raises fault and shuts down on expiry; zero disables.
// - start method 0 or 3 direct, 1 speed tracking, 2 pre-excitation.
// - pre-excitation magnetises before acceleration, only for induction motors.
// - stop method picks deceleration stop or coasting stop.
// - panel jog key while stopped runs forward; release decelerates to stop.
// - forward or reverse jog inputs while stopped jog; release decelerates.
// - main and auxiliary frequency channels, usable singly or switched.
// - main frequency selector picks exactly one of nine sources.
`timescale 1ns/1ns
`default_nettype none
`include "drive_run_regs.svh"
module drive_run_command_control #(
	parameter int unsigned UNIT_CYCLES   = `TIMEOUT_UNIT_MS * `CLK_KHZ,
	parameter int unsigned PREEXC_CYCLES = `PREEXC_TIME_MS * `CLK_KHZ
) (
	input  wire logic                 core_clk,
	input  wire logic                 srst,
	input  wire logic                 clk_en,
	input  wire logic [1:0]           run_command_source_select,
	input  wire logic [1:0]           terminal_command_style,
	input  wire logic [4:0][5:0]      input_function_selects,
	input  wire logic [15:0]          comm_timeout_setting,
	input  wire logic [1:0]           start_method_select,
	input  wire logic                 stop_method_select,
	input  wire logic [3:0]           main_freq_source_select,
	input  wire logic                 aux_channel_select,
	input  wire logic                 motor_is_induction,
	input  wire logic                 motor_at_zero,
	input  wire logic [4:0]           digital_inputs,
	input  wire logic                 run_key,
	input  wire logic                 stop_key,
	input  wire logic                 jog_key,
	input  wire logic                 comm_frame_valid,
	input  wire logic                 comm_start,
	input  wire logic                 comm_stop,
	input  wire logic                 comm_reverse,
	input  wire logic                 comm_fault_clear,
	output logic                      run_indicator,
	output logic                      motor_enable,
	output logic                      run_reverse,
	output logic                      jog_active,
	output logic                      pre_excite,
	output logic                      speed_track,
	output logic                      decel_stop,
	output logic                      coast_stop,
	output logic                      comm_timeout_fault,
	output logic [`MAIN_SOURCES-1:0]  main_source_onehot,
	output logic                      aux_channel_active,
	output drive_run_pkg::drive_state_type drive_state
);
	import drive_run_pkg::*;

	typedef struct packed {
		logic [4:0]               di_s1;
		logic [4:0]               di_s2;
		logic [4:0]               di_d;
		logic [2:0]               key_s1;
		logic [2:0]               key_s2;
		logic [2:0]               key_d;
		logic                     run_cmd;
		logic                     rev_cmd;
		logic                     jog_rev;
		drive_state_type          fsm;
		logic [31:0]              phase_cnt;
		logic [31:0]              tick_cnt;
		logic [15:0]              unit_cnt;
		logic                     fault;
		logic                     run_ind;
		logic                     coast;
		logic                     decel;
		logic                     preexc;
		logic                     track;
		logic                     jog;
		logic                     enable;
		logic                     dir;
		logic [`MAIN_SOURCES-1:0] main_sel;
		logic                     aux_sel;
	} state_type;

	state_type cur;
	state_type next_cur;

	// per-input function decode, one bit per digital input
	logic [4:0] is_fwd;
	logic [4:0] is_rev;
	logic [4:0] is_stop;
	logic [4:0] is_finch;
	logic [4:0] is_rinch;
	genvar gi;
	generate
		for (gi = 0; gi < 5; gi = gi + 1) begin : g_func
			assign is_fwd[gi]   = input_function_selects[gi] == `FUNC_FWD;
			assign is_rev[gi]   = input_function_selects[gi] == `FUNC_REV;
			assign is_stop[gi]  = input_function_selects[gi] == `FUNC_STOP_HOLD;
			assign is_finch[gi] = input_function_selects[gi] == `FUNC_FWD_INCH;
			assign is_rinch[gi] = input_function_selects[gi] == `FUNC_REV_INCH;
		end
	endgenerate

	// function levels and closing edges from the synchronised inputs
	logic fwd_lvl, rev_lvl, stop_lvl, finch_lvl, rinch_lvl, fwd_rise, rev_rise;
	logic run_rise, stop_rise, src_panel, src_term, src_comm, three_wire;
	assign fwd_lvl    = |(cur.di_s2 & is_fwd);
	assign rev_lvl    = |(cur.di_s2 & is_rev);
	assign stop_lvl   = |(cur.di_s2 & is_stop);
	assign finch_lvl  = |(cur.di_s2 & is_finch);
	assign rinch_lvl  = |(cur.di_s2 & is_rinch);
	assign fwd_rise   = |(cur.di_s2 & ~cur.di_d & is_fwd);
	assign rev_rise   = |(cur.di_s2 & ~cur.di_d & is_rev);
	assign run_rise   = cur.key_s2[0] & ~cur.key_d[0];
	assign stop_rise  = cur.key_s2[1] & ~cur.key_d[1];
	assign src_panel  = run_command_source_select == `SRC_PANEL;
	assign src_term   = run_command_source_select == `SRC_TERMINAL;
	assign src_comm   = run_command_source_select == `SRC_COMM;
	assign three_wire = terminal_command_style == `STYLE_THREE_WIRE;

	// command arbitration, sequencing and timeout
	always_comb begin
		logic jog_req;
		logic jog_dir;
		logic expire;
		jog_req  = 1'b0;
		jog_dir  = 1'b0;
		expire   = 1'b0;
		next_cur = cur;
		next_cur.di_s1  = digital_inputs;
		next_cur.di_s2  = cur.di_s1;
		next_cur.di_d   = cur.di_s2;
		next_cur.key_s1 = {jog_key, stop_key, run_key};
		next_cur.key_s2 = cur.key_s1;
		next_cur.key_d  = cur.key_s2;
		next_cur.decel  = 1'b0;
		next_cur.coast  = 1'b0;
		// source-specific run command
		if (src_panel) begin
			if (stop_rise) begin
				next_cur.run_cmd = 1'b0;
			end else if (run_rise) begin
				next_cur.run_cmd = 1'b1;
				next_cur.rev_cmd = 1'b0;
			end
			jog_req = cur.key_s2[2];
		end else if (src_term) begin
			if (three_wire) begin
				if (!stop_lvl) begin
					next_cur.run_cmd = 1'b0;
				end else if (rev_rise) begin
					next_cur.run_cmd = 1'b1;
					next_cur.rev_cmd = 1'b1;
				end else if (fwd_rise) begin
					next_cur.run_cmd = 1'b1;
					next_cur.rev_cmd = 1'b0;
				end
			end else if (terminal_command_style == `STYLE_TWO_WIRE) begin
				next_cur.run_cmd = fwd_lvl ^ rev_lvl;
				next_cur.rev_cmd = rev_lvl & ~fwd_lvl;
			end else begin
				next_cur.run_cmd = 1'b0;
			end
			jog_req = finch_lvl ^ rinch_lvl;
			jog_dir = rinch_lvl;
		end else if (src_comm) begin
			if (comm_stop) begin
				next_cur.run_cmd = 1'b0;
			end else if (comm_start) begin
				next_cur.run_cmd = 1'b1;
				next_cur.rev_cmd = comm_reverse;
			end
		end else begin
			next_cur.run_cmd = 1'b0;
		end
		// host silence watchdog, restarted by every valid frame
		if (!src_comm || comm_timeout_setting == 16'h0000 || comm_frame_valid) begin
			next_cur.tick_cnt = 32'h0;
			next_cur.unit_cnt = 16'h0000;
		end else if (cur.tick_cnt == UNIT_CYCLES - 1) begin
			next_cur.tick_cnt = 32'h0;
			if (cur.unit_cnt + 16'h0001 >= comm_timeout_setting) begin
				expire            = 1'b1;
				next_cur.unit_cnt = 16'h0000;
			end else begin
				next_cur.unit_cnt = cur.unit_cnt + 16'h0001;
			end
		end else begin
			next_cur.tick_cnt = cur.tick_cnt + 32'h1;
		end
		// fault set wins over clear
		if (expire) begin
			next_cur.fault = 1'b1;
		end else if (comm_fault_clear) begin
			next_cur.fault = 1'b0;
		end
		if (expire || cur.fault) begin
			next_cur.run_cmd = 1'b0;
			jog_req          = 1'b0;
		end
		// drive sequencer
		case (cur.fsm)
			ST_IDLE: begin
				next_cur.jog = 1'b0;
				if (next_cur.run_cmd || (jog_req && !cur.run_cmd)) begin
					next_cur.jog     = !next_cur.run_cmd;
					next_cur.jog_rev = jog_dir;
					next_cur.run_ind = 1'b1;
					next_cur.track   = 1'b0;
					if (start_method_select == `START_PREEXC && motor_is_induction) begin
						next_cur.fsm       = ST_START;
						next_cur.preexc    = 1'b1;
						next_cur.phase_cnt = 32'h0;
					end else begin
						next_cur.fsm   = ST_RUN;
						next_cur.track = start_method_select == `START_TRACK;
					end
				end
			end
			ST_START: begin
				if (!(cur.jog ? jog_req : next_cur.run_cmd)) begin
					next_cur.preexc = 1'b0;
					next_cur.fsm    = ST_STOP;
				end else if (cur.phase_cnt == PREEXC_CYCLES - 1) begin
					next_cur.preexc = 1'b0;
					next_cur.fsm    = ST_RUN;
				end else begin
					next_cur.phase_cnt = cur.phase_cnt + 32'h1;
				end
			end
			ST_RUN: begin
				next_cur.track = 1'b0;
				if (!(cur.jog ? jog_req : next_cur.run_cmd)) begin
					next_cur.fsm = ST_STOP;
				end
			end
			ST_STOP: begin
				if (cur.jog || stop_method_select == `STOP_DECEL) begin
					next_cur.decel = !motor_at_zero;
					if (motor_at_zero) begin
						next_cur.fsm     = ST_IDLE;
						next_cur.run_ind = 1'b0;
					end
				end else begin
					next_cur.coast   = 1'b1;
					next_cur.fsm     = ST_IDLE;
					next_cur.run_ind = 1'b0;
				end
				if (!cur.jog && next_cur.run_cmd) begin
					next_cur.fsm = ST_RUN;
				end
			end
			default: begin
				next_cur.fsm = ST_IDLE;
			end
		endcase
		next_cur.enable = next_cur.fsm != ST_IDLE; // registered copy of the state decode
		next_cur.dir    = next_cur.jog ? next_cur.jog_rev : next_cur.rev_cmd;
		// frequency channel selection, invalid codes keep the last choice
		if (main_freq_source_select < 4'(`MAIN_SOURCES)) begin
			next_cur.main_sel = `MAIN_SOURCES'(1) << main_freq_source_select;
		end
		next_cur.aux_sel = aux_channel_select;
	end

	// state register, frozen while clk_en is low
	always_ff @(posedge core_clk) begin
		if (srst) begin
			cur          <= '0;
			cur.fsm      <= ST_IDLE;
			cur.main_sel <= `MAIN_SEL_RESET;
		end else if (clk_en) begin
			cur <= next_cur;
		end
	end

	assign run_indicator      = cur.run_ind;
	assign motor_enable       = cur.enable;
	assign run_reverse        = cur.dir;
	assign jog_active         = cur.jog;
	assign pre_excite         = cur.preexc;
	assign speed_track        = cur.track;
	assign decel_stop         = cur.decel;
	assign coast_stop         = cur.coast;
	assign comm_timeout_fault = cur.fault;
	assign main_source_onehot = cur.main_sel;
	assign aux_channel_active = cur.aux_sel;
	assign drive_state        = cur.fsm;

	// checks
	sequence s_idle_start;
		clk_en && cur.fsm == ST_IDLE && next_cur.run_cmd;
	endsequence
	property p_run_start;
		@(posedge core_clk) disable iff (srst) s_idle_start |=> run_indicator;
	endproperty
	a_run_start: assert property (p_run_start) else $error("run did not light indicator");
	property p_two_wire_stop;
		@(posedge core_clk) disable iff (srst)
			clk_en && src_term && !three_wire && terminal_command_style == `STYLE_TWO_WIRE
			&& fwd_lvl == rev_lvl |=> !cur.run_cmd;
	endproperty
	a_two_wire_stop: assert property (p_two_wire_stop) else $error("two-wire stop missed");
	property p_two_wire_rev;
		@(posedge core_clk) disable iff (srst)
			clk_en && src_term && terminal_command_style == `STYLE_TWO_WIRE && rev_lvl && !fwd_lvl
			&& !cur.fault |=> cur.run_cmd && cur.rev_cmd;
	endproperty
	a_two_wire_rev: assert property (p_two_wire_rev) else $error("reverse run missed");
	property p_three_wire_stop;
		@(posedge core_clk) disable iff (srst)
			clk_en && src_term && three_wire && !stop_lvl |=> !cur.run_cmd;
	endproperty
	a_three_wire_stop: assert property (p_three_wire_stop) else $error("stop hold ignored");
	property p_level_ignored;
		@(posedge core_clk) disable iff (srst)
			clk_en && src_term && three_wire && stop_lvl && !fwd_rise && !rev_rise
			&& !cur.fault && !comm_timeout_fault |=> cur.run_cmd == $past(cur.run_cmd);
	endproperty
	a_level_ignored: assert property (p_level_ignored) else $error("held level acted");
	property p_timeout_fault;
		@(posedge core_clk) disable iff (srst)
			clk_en && src_comm && comm_timeout_setting == 16'h0000 && !cur.fault |=> !cur.fault;
	endproperty
	a_timeout_fault: assert property (p_timeout_fault) else $error("disabled timeout fired");
	property p_fault_stops;
		@(posedge core_clk) disable iff (srst) cur.fault |-> !cur.run_cmd;
	endproperty
	a_fault_stops: assert property (p_fault_stops) else $error("run while faulted");
	property p_preexc_only_induction;
		@(posedge core_clk) disable iff (srst)
			s_idle_start ##0 !motor_is_induction |=> !pre_excite && cur.fsm == ST_RUN;
	endproperty
	a_preexc_only_induction: assert property (p_preexc_only_induction) else $error("bad preexcite");
	property p_coast;
		@(posedge core_clk) disable iff (srst)
			clk_en && cur.fsm == ST_STOP && !cur.jog && stop_method_select == `STOP_COAST
			&& !next_cur.run_cmd |=> coast_stop && cur.fsm == ST_IDLE;
	endproperty
	a_coast: assert property (p_coast) else $error("coast stop missed");
	property p_main_onehot;
		@(posedge core_clk) disable iff (srst) $onehot(main_source_onehot);
	endproperty
	a_main_onehot: assert property (p_main_onehot) else $error("main source not one-hot");
	property p_jog_blocked;
		@(posedge core_clk) disable iff (srst)
			clk_en && cur.run_cmd |=> !$rose(jog_active);
	endproperty
	a_jog_blocked: assert property (p_jog_blocked) else $error("jog during run command");
	property p_counter_idle;
		@(posedge core_clk) disable iff (srst) clk_en && !src_comm |=> cur.tick_cnt == 32'h0;
	endproperty
	a_counter_idle: assert property (p_counter_idle) else $error("timeout counted off-source");
endmodule : drive_run_command_control
`default_nettype wire

// >>> tb/run_partner.sv
// Purpose: operator keys, terminal contacts and fieldbus host facing the run-command block
// Assumes: every line changes just after a falling edge of core_clk
// Notes: host strobes last one cycle and fall back low between frames
`timescale 1ns/1ns
`default_nettype none
module run_partner (
	input  wire logic       core_clk,
	output var logic [4:0]  digital_inputs,
	output var logic        run_key,
	output var logic        stop_key,
	output var logic        jog_key,
	output var logic        comm_frame_valid,
	output var logic        comm_start,
	output var logic        comm_stop,
	output var logic        comm_reverse,
	output var logic        comm_fault_clear
);
	// everything open and quiet at time zero
	initial begin
		digital_inputs = 5'h00;
		{run_key, stop_key, jog_key} = 3'h0;
		{comm_frame_valid, comm_start, comm_stop, comm_reverse, comm_fault_clear} = 5'h00;
	end
	// panel keys: run, stop, jog
	task automatic keys(input logic [2:0] k);
		@(negedge core_clk);
		{run_key, stop_key, jog_key} = k;
	endtask : keys
	// contacts stay as set until changed; the operator holds stop-hold closed while running
	task automatic contacts(input logic [4:0] d);
		@(negedge core_clk);
		digital_inputs = d;
	endtask : contacts
	// host is master: one frame start, stop, reverse, clear, then quiet
	task automatic frame(input logic [3:0] c);
		@(negedge core_clk);
		comm_frame_valid = 1'b1;
		{comm_start, comm_stop, comm_reverse, comm_fault_clear} = c;
		@(negedge core_clk);
		{comm_frame_valid, comm_start, comm_stop, comm_reverse, comm_fault_clear} = 5'h00;
	endtask : frame
endmodule : run_partner
`default_nettype wire

// >>> tb/drive_run_command_control_tb_top.sv
// Purpose: self-checking bench for the run-command arbitration block
// Assumes: short timeout unit and pre-excitation counts via parameters
// Notes: inputs change at falling edges, outputs are sampled there too
`timescale 1ns/1ns
`default_nettype none
`include "drive_run_regs.svh"
module drive_run_command_control_tb_top;
	import drive_run_pkg::*;
	logic            core_clk, srst, motor_is_induction, motor_at_zero, aux_channel_select;
	logic            clk_en;
	logic [1:0]      run_command_source_select, terminal_command_style, start_method_select;
	logic [4:0][5:0] input_function_selects;
	logic [15:0]     comm_timeout_setting;
	logic            stop_method_select;
	logic [3:0]      main_freq_source_select;
	logic [4:0]      digital_inputs;
	logic            run_key, stop_key, jog_key;
	logic            comm_frame_valid, comm_start, comm_stop, comm_reverse, comm_fault_clear;
	logic            run_indicator, motor_enable, run_reverse, jog_active, pre_excite;
	logic            speed_track, decel_stop, coast_stop, comm_timeout_fault, aux_channel_active;
	logic [8:0]      main_source_onehot;
	drive_state_type drive_state;
	int              miscompares, total_checks, coasts, tracks;
	drive_run_command_control #(.UNIT_CYCLES(4), .PREEXC_CYCLES(3)) i_dut (
		.core_clk(core_clk), .srst(srst), .clk_en(clk_en),
		.run_command_source_select(run_command_source_select),
		.terminal_command_style(terminal_command_style),
		.input_function_selects(input_function_selects),
		.comm_timeout_setting(comm_timeout_setting), .start_method_select(start_method_select),
		.stop_method_select(stop_method_select), .main_freq_source_select(main_freq_source_select),
		.aux_channel_select(aux_channel_select), .motor_is_induction(motor_is_induction),
		.motor_at_zero(motor_at_zero), .digital_inputs(digital_inputs), .run_key(run_key),
		.stop_key(stop_key), .jog_key(jog_key), .comm_frame_valid(comm_frame_valid),
		.comm_start(comm_start), .comm_stop(comm_stop), .comm_reverse(comm_reverse),
		.comm_fault_clear(comm_fault_clear), .run_indicator(run_indicator),
		.motor_enable(motor_enable), .run_reverse(run_reverse), .jog_active(jog_active),
		.pre_excite(pre_excite), .speed_track(speed_track), .decel_stop(decel_stop),
		.coast_stop(coast_stop), .comm_timeout_fault(comm_timeout_fault),
		.main_source_onehot(main_source_onehot), .aux_channel_active(aux_channel_active),
		.drive_state(drive_state)
	);
	run_partner i_partner (
		.core_clk(core_clk), .digital_inputs(digital_inputs), .run_key(run_key),
		.stop_key(stop_key), .jog_key(jog_key), .comm_frame_valid(comm_frame_valid),
		.comm_start(comm_start), .comm_stop(comm_stop), .comm_reverse(comm_reverse),
		.comm_fault_clear(comm_fault_clear)
	);
	// 25 MHz clock
	initial core_clk = 1'b0;
	always #20 core_clk = ~core_clk;
	// count one-cycle pulses, sampled where settled
	always @(negedge core_clk) begin
		if (coast_stop === 1'b1) coasts++;
		if (speed_track === 1'b1) tracks++;
	end
	task automatic cyc(input int n);
		repeat (n) @(negedge core_clk);
	endtask : cyc
	task automatic check(input string what, input logic [8:0] seen, input logic [8:0] exp);
		total_checks++;
		if (seen !== exp) begin
			miscompares++;
			$display("FAIL %s expected %h seen %h", what, exp, seen);
		end
	endtask : check
	task automatic conclude();
		if (miscompares == 0 && total_checks > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask : conclude
	// panel run and decelerating stop
	task automatic sc_panel();
		run_command_source_select = `SRC_PANEL;
		motor_at_zero = 1'b0;
		i_partner.keys(3'h4);
		cyc(5);
		check("run_ind", run_indicator, 1'b1);
		check("state", drive_state, ST_RUN);
		i_partner.keys(3'h2);
		cyc(5);
		check("decel", decel_stop, 1'b1);
		motor_at_zero = 1'b1;
		cyc(3);
		check("run_ind", run_indicator, 1'b0);
		i_partner.keys(3'h0);
	endtask : sc_panel
	// two-wire: forward on terminal two, reverse on terminal four
	task automatic sc_two_wire();
		run_command_source_select = `SRC_TERMINAL;
		terminal_command_style = `STYLE_TWO_WIRE;
		input_function_selects[1] = `FUNC_FWD;
		input_function_selects[3] = `FUNC_REV;
		i_partner.contacts(5'h02);
		cyc(5);
		check("en", motor_enable, 1'b1);
		check("rev", run_reverse, 1'b0);
		i_partner.contacts(5'h0A);
		cyc(6);
		check("en", motor_enable, 1'b0);
		i_partner.contacts(5'h08);
		cyc(5);
		check("rev", run_reverse, 1'b1);
		check("en", motor_enable, 1'b1);
		i_partner.contacts(5'h00);
		cyc(6);
		check("en", motor_enable, 1'b0);
	endtask : sc_two_wire
	// three-wire: start on two, stop-hold on three, reverse on four
	task automatic sc_three_wire();
		terminal_command_style = `STYLE_THREE_WIRE;
		input_function_selects[2] = `FUNC_STOP_HOLD;
		i_partner.contacts(5'h04);
		cyc(5);
		check("en", motor_enable, 1'b0);
		i_partner.contacts(5'h06);
		cyc(5);
		check("en", motor_enable, 1'b1);
		i_partner.contacts(5'h0C);
		cyc(5);
		check("rev", run_reverse, 1'b1);
		i_partner.contacts(5'h06);
		cyc(5);
		check("rev", run_reverse, 1'b0);
		check("en", motor_enable, 1'b1);
		i_partner.contacts(5'h02);
		cyc(6);
		check("en", motor_enable, 1'b0);
		i_partner.contacts(5'h06);
		cyc(5);
		check("en", motor_enable, 1'b0);
	endtask : sc_three_wire
	// jog from panel key and from terminal inputs, and jog ignored while running
	task automatic sc_jog();
		i_partner.contacts(5'h00);
		run_command_source_select = `SRC_PANEL;
		i_partner.keys(3'h1);
		cyc(5);
		check("jog", jog_active, 1'b1);
		check("rev", run_reverse, 1'b0);
		motor_at_zero = 1'b0;
		i_partner.keys(3'h0);
		cyc(5);
		check("decel", decel_stop, 1'b1);
		motor_at_zero = 1'b1;
		run_command_source_select = `SRC_TERMINAL;
		terminal_command_style = `STYLE_TWO_WIRE;
		input_function_selects[0] = `FUNC_FWD_INCH;
		input_function_selects[4] = `FUNC_REV_INCH;
		i_partner.contacts(5'h10);
		cyc(5);
		check("jog", jog_active, 1'b1);
		check("rev", run_reverse, 1'b1);
		i_partner.contacts(5'h00);
		cyc(6);
		check("en", motor_enable, 1'b0);
		i_partner.contacts(5'h02);
		cyc(5);
		i_partner.contacts(5'h12);
		cyc(5);
		check("jog", jog_active, 1'b0);
		check("rev", run_reverse, 1'b0);
		i_partner.contacts(5'h00);
		cyc(6);
	endtask : sc_jog
	// host start and keep-alive frames, timeout fault, refusal and clear
	task automatic sc_comm();
		run_command_source_select = `SRC_COMM;
		comm_timeout_setting = 16'h0002;
		i_partner.frame(4'h8);
		cyc(2);
		check("en", motor_enable, 1'b1);
		repeat (3) begin
			cyc(4);
			i_partner.frame(4'h0);
		end
		check("fault", comm_timeout_fault, 1'b0);
		cyc(14);
		check("fault", comm_timeout_fault, 1'b1);
		check("en", motor_enable, 1'b0);
		i_partner.frame(4'h8);
		cyc(2);
		check("en", motor_enable, 1'b0);
		i_partner.frame(4'h1);
		i_partner.frame(4'hA);
		comm_timeout_setting = 16'h0000;
		cyc(2);
		check("en", motor_enable, 1'b1);
		check("rev", run_reverse, 1'b1);
		cyc(30);
		check("fault", comm_timeout_fault, 1'b0);
	endtask : sc_comm
	// start methods 0 to 2, both stop methods
	task automatic sc_methods();
		motor_is_induction = 1'b1;
		i_partner.frame(4'h4);
		cyc(4);
		for (int m = 0; m < 3; m++) begin
			start_method_select = m[1:0];
			stop_method_select = m[0];
			i_partner.frame(4'h8);
			cyc(1);
			check("preexc", pre_excite, m == 2);
			check("state", drive_state, (m == 2) ? ST_START : ST_RUN);
			cyc(4);
			check("state", drive_state, ST_RUN);
			i_partner.frame(4'h4);
			cyc(4);
			check("en", motor_enable, 1'b0);
		end
		check("coasts", coasts, 1);
		check("tracks", tracks, 1);
		motor_is_induction = 1'b0;
		i_partner.frame(4'h8);
		cyc(1);
		check("preexc", pre_excite, 1'b0);
	endtask : sc_methods
	// main source one-hot and auxiliary channel switch
	task automatic sc_freq();
		for (int s = 0; s < 10; s++) begin
			main_freq_source_select = s[3:0];
			cyc(2);
			check("main", main_source_onehot, 9'h001 << ((s < 9) ? s : 8));
		end
		aux_channel_select = 1'b1;
		cyc(2);
		check("aux", aux_channel_active, 1'b1);
	endtask : sc_freq
	// clk_en low freezes everything, host pulses are lost; reset still acts while frozen
	task automatic sc_freeze();
		clk_en = 1'b0;
		main_freq_source_select = 4'h2;
		i_partner.frame(4'h4);
		cyc(2);
		check("main_frz", main_source_onehot, 9'h100);
		check("en_frz", motor_enable, 1'b1);
		clk_en = 1'b1;
		cyc(2);
		check("main", main_source_onehot, 9'h004);
		check("en", motor_enable, 1'b1);
		i_partner.frame(4'h4);
		cyc(4);
		check("en", motor_enable, 1'b0);
		i_partner.frame(4'h8);
		{srst, clk_en} = 2'h2;
		cyc(3);
		check("main_rst", main_source_onehot, `MAIN_SEL_RESET);
		check("en_rst", motor_enable, 1'b0);
		{srst, clk_en} = 2'h1;
		cyc(2);
		check("en", motor_enable, 1'b0);
	endtask : sc_freeze
	// watchdog cuts a hang short
	initial begin
		repeat (5000) @(posedge core_clk);
		miscompares++;
		conclude();
	end
	// reset, then the scenarios
	initial begin
		{srst, motor_is_induction, motor_at_zero, aux_channel_select} = 4'hC;
		clk_en = 1'b1;
		{run_command_source_select, terminal_command_style, start_method_select} = 6'h00;
		input_function_selects = '0;
		comm_timeout_setting = 16'h0000;
		stop_method_select = 1'b0;
		main_freq_source_select = 4'h0;
		{miscompares, total_checks, coasts, tracks} = {4{32'sd0}};
		cyc(6);
		srst = 1'b0;
		cyc(1);
		check("main_rst", main_source_onehot, `MAIN_SEL_RESET);
		sc_panel();
		sc_two_wire();
		sc_three_wire();
		sc_jog();
		sc_comm();
		sc_methods();
		sc_freq();
		sc_freeze();
		conclude();
	end
endmodule : drive_run_command_control_tb_top
`default_nettype wire
